// ===== include/plpaps_pkg.sv
// constants, register map and state types of the port latch / pull-up / analog select block
// Operation
// RULE1 - pull-up select bit 0 disconnects, 1 connects the pin's on-chip pull-up
// RULE2 - small variants: software keeps port-0 pull-up bit 6, port-13 bit 1 zero
// RULE3 - pull-up only acts on input-mode pins, never on output or alternate output
// RULE4 - configuration register picks digital port or analog input for nine pins
// RULE5 - field N makes lowest N shared pins digital; values above 9 prohibited
// RULE6 - reset clears configuration register, all nine shared pins analog
// RULE7 - configuration register accepts bit and byte writes
// RULE8 - any configuration register write inserts one wait cycle
// RULE9 - software avoids configuration writes while peripheral clock is stopped
// RULE10 - software allocates digital shared pins upward from the first port-8 pin
// RULE11 - software sets analog pins to input in port-8 and port-9 direction
// RULE12 - output mode: write loads latch, latch drives the pin
// RULE13 - latch holds until written again; reset clears it
// RULE14 - input mode: write updates latch, pin stays undriven
// RULE15 - output-mode read returns latch, latch unchanged
// RULE16 - input-mode read returns sampled pin level, latch unchanged
// RULE17 - output-mode operation uses latch operand, result to latch and pin
// RULE18 - input-mode operation uses pin operand, result to latch, pin undriven
// RULE19 - bit instruction reads byte, modifies bit, writes whole byte back
// RULE20 - software rewrites latch before turning an input into an output
// RULE21 - fixed-zero pull-up bits read zero and ignore writes
package plpaps_pkg;

   // ***********************************************
   // port slots: P0 P1 P3 P4 P7 P12 P13 P8 P9
   // ***********************************************
   localparam int NSLOT = 9;
   localparam int SLOT_P1 = 1;
   localparam int SLOT_P8 = 7;
   localparam int SLOT_P9 = 8;

   localparam logic [15:0] DATA_ADDR [NSLOT] = '{16'hFF00, 16'hFF01, 16'hFF03, 16'hFF04,
      16'hFF07, 16'hFF0C, 16'hFF0D, 16'hFF08, 16'hFF09};
   localparam logic [15:0] DIR_ADDR [NSLOT] = '{16'hFF20, 16'hFF21, 16'hFF23, 16'hFF24,
      16'hFF27, 16'hFF2C, 16'hFF2D, 16'hFF28, 16'hFF29};
   // slots 7 and 8 have no pull-up register; their mask is zero
   localparam logic [15:0] PU_ADDR [NSLOT] = '{16'hFF30, 16'hFF31, 16'hFF33, 16'hFF34,
      16'hFF37, 16'hFF3C, 16'hFF3D, 16'h0000, 16'h0000};
   localparam logic [15:0] ANALOG_DIGITAL_PIN_CONFIG_ADDR = 16'hFF2F;

   // implemented bits per slot
   localparam logic [7:0] DATA_MASK [NSLOT] = '{8'h43, 8'hFF, 8'h0F, 8'h03,
      8'h0F, 8'h1F, 8'h03, 8'hFF, 8'h01};
   localparam logic [7:0] PU_MASK [NSLOT] = '{8'h43, 8'hFF, 8'h0F, 8'h03,
      8'h7F, 8'h01, 8'h02, 8'h00, 8'h00};

   // ***********************************************
   // reset values and limits
   // ***********************************************
   localparam logic [7:0] LAT_RST = 8'h00;
   localparam logic [7:0] DIR_RST = 8'hFF;
   localparam logic [7:0] PU_RST = 8'h00;
   localparam logic [3:0] ANALOG_DIGITAL_PIN_CONFIG_RST = 4'h0;
   localparam logic [3:0] ANALOG_DIGITAL_PIN_CONFIG_MAX = 4'h9;

   typedef struct packed {
      logic [3:0] analog_digital_pin_config;
      logic [NSLOT-1:0][7:0] pu;
      logic [NSLOT-1:0][7:0] dir;
      logic [NSLOT-1:0][7:0] lat;
      logic wt;
      logic [7:0] rdata;
      logic rvalid;
   } plpaps_st_t;

endpackage : plpaps_pkg

// ===== rtl/plpaps_slice.sv
// one 8-bit port slice: read mux, output enable and pull-up gating
`timescale 1ns/100ps
`default_nettype none
module plpaps_slice #(
   parameter logic [7:0] MASK = 8'hFF
) (
   input wire logic [7:0] i_lat,
   input wire logic [7:0] i_dir,
   input wire logic [7:0] i_pin,
   input wire logic [7:0] i_pu,
   input wire logic [7:0] i_alt,
   input wire logic [7:0] i_dig,
   output logic [7:0] o_rd,
   output logic [7:0] o_oe,
   output logic [7:0] o_pu
);

   // dir bit 1 means input; analog pins read zero and are never driven
   always_comb begin
      o_rd = ((i_dir & i_pin) | (~i_dir & i_lat)) & i_dig & MASK; // see RULE15 see RULE16
      o_oe = ~i_dir & i_dig & MASK; // see RULE12 see RULE14
      o_pu = i_pu & i_dir & ~i_alt & MASK; // see RULE1 see RULE3
   end

endmodule : plpaps_slice
`default_nettype wire

// ===== rtl/plpaps_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
`default_nettype none
module plpaps_sync #(
   parameter int W = 8
) (
   input wire logic i_ref_clk,
   input wire logic i_reset_n,
   input wire logic [W-1:0] i_d,
   output logic [W-1:0] o_q
);

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] q;
   } plpaps_sync_st_t;

   plpaps_sync_st_t st_r;
   plpaps_sync_st_t st_nxt;

   // s1 feeds only s2; q follows once s2 and s3 agree
   always_comb begin
      st_nxt = st_r;
      st_nxt.s1 = i_d;
      st_nxt.s2 = st_r.s1;
      st_nxt.s3 = st_r.s2;
      st_nxt.q = (~(st_r.s2 ^ st_r.s3) & st_r.s2) | ((st_r.s2 ^ st_r.s3) & st_r.q);
   end

   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign o_q = st_r.q;

endmodule : plpaps_sync
`default_nettype wire

// ===== rtl/plpaps_top.sv
// port latches, direction, pull-up select and analog/digital pin configuration
`timescale 1ns/100ps
`default_nettype none
module plpaps_top (
   input wire logic i_ref_clk,
   input wire logic i_reset_n,
   input wire logic [15:0] i_addr,
   input wire logic i_rd,
   input wire logic i_wr,
   input wire logic i_bit,
   input wire logic [2:0] i_bit_idx,
   input wire logic i_bit_val,
   input wire logic [7:0] i_wdata,
   output logic [7:0] o_rdata,
   output logic o_rvalid,
   output logic o_wait,
   input wire logic [plpaps_pkg::NSLOT-1:0][7:0] i_pin_in,
   input wire logic [plpaps_pkg::NSLOT-1:0][7:0] i_alt_out_en,
   output logic [plpaps_pkg::NSLOT-1:0][7:0] o_pin_out,
   output logic [plpaps_pkg::NSLOT-1:0][7:0] o_pin_oe,
   output logic [plpaps_pkg::NSLOT-1:0][7:0] o_pullup_en,
   output logic [8:0] o_analog_sel
);
   import plpaps_pkg::*;

   // ***********************************************
   // state and helpers
   // ***********************************************
   plpaps_st_t st_r;
   plpaps_st_t st_nxt;

   // pin_q: filtered pad levels; rdv: per-slot read view seen by the cpu
   // dig: per-bit digital enable, all ones except on the converter-shared slots
   logic [NSLOT-1:0][7:0] pin_q;
   logic [NSLOT-1:0][7:0] rdv;
   logic [NSLOT-1:0][7:0] dig;
   logic [8:0] dig9;
   logic analog_digital_pin_config_wr;

   // ***********************************************
   // pin synchronisers
   // ***********************************************

   // pins are asynchronous to the cpu clock
   // the filter costs about four edges, so a read just after a pad change sees the old level
   plpaps_sync #(
      .W(NSLOT * 8)
   ) u_sync (
      .i_ref_clk(i_ref_clk),
      .i_reset_n(i_reset_n),
      .i_d(i_pin_in),
      .o_q(pin_q)
   );

   // ***********************************************
   // analog / digital decode
   // ***********************************************

   // value N turns on the lowest N shared pins as digital
   // prohibited values never reach the register, so the shift stays inside ten bits
   assign dig9 = 9'((10'h001 << st_r.analog_digital_pin_config) - 10'h001); // see RULE4 see RULE5
   assign o_analog_sel = ~dig9; // see RULE4

   // only slots 7 and 8 share pins with the converter
   always_comb begin
      for (int s = 0; s < NSLOT; s++) begin
         dig[s] = 8'hFF;
      end
      dig[SLOT_P8] = dig9[7:0];
      dig[SLOT_P9] = {7'h00, dig9[8]};
   end

   // ***********************************************
   // port slices
   // ***********************************************
   // one slice per port keeps each implemented-bit mask next to the logic using it
   for (genvar g = 0; g < NSLOT; g++) begin : g_slice
      plpaps_slice #(
         .MASK(DATA_MASK[g])
      ) u_slice (
         .i_lat(st_r.lat[g]),
         .i_dir(st_r.dir[g]),
         .i_pin(pin_q[g]),
         .i_pu(st_r.pu[g]),
         .i_alt(i_alt_out_en[g]),
         .i_dig(dig[g]),
         .o_rd(rdv[g]),
         .o_oe(o_pin_oe[g]),
         .o_pu(o_pullup_en[g])
      );
   end

   // latch always reaches the pad; the enable decides whether it shows
   assign o_pin_out = st_r.lat; // see RULE12

   // ***********************************************
   // register access
   // ***********************************************

   // a configuration write is held off for one cycle, then taken
   // dropping i_wr in the wait cycle loses the write: the cpu side must hold it
   // only this register pays the wait; every other register answers at once
   assign analog_digital_pin_config_wr = i_wr && (i_addr == ANALOG_DIGITAL_PIN_CONFIG_ADDR);
   assign o_wait = analog_digital_pin_config_wr && !st_r.wt; // see RULE8

   always_comb begin
      logic [7:0] cur;
      logic [7:0] wv;
      logic [7:0] bm;
      cur = 8'h00;
      wv = 8'h00;
      bm = 8'h00;
      st_nxt = st_r;
      st_nxt.rvalid = 1'b0;

      // current view of the addressed register; unmapped reads zero
      for (int s = 0; s < NSLOT; s++) begin
         if (i_addr == DATA_ADDR[s]) begin
            cur = rdv[s]; // see RULE17 see RULE18
         end
         if (i_addr == DIR_ADDR[s]) begin
            cur = st_r.dir[s];
         end
         if ((PU_MASK[s] != 8'h00) && (i_addr == PU_ADDR[s])) begin
            cur = st_r.pu[s];
         end
      end
      if (i_addr == ANALOG_DIGITAL_PIN_CONFIG_ADDR) begin
         cur = {4'h0, st_r.analog_digital_pin_config};
      end

      // bit instructions rewrite the whole byte from the current view
      bm = 8'h01 << i_bit_idx;
      if (i_bit) begin
         wv = (cur & ~bm) | ({8{i_bit_val}} & bm); // see RULE19 see RULE7
      end else begin
         wv = i_wdata;
      end

      // reads never touch the latch
      if (i_rd) begin
         st_nxt.rdata = cur; // see RULE15 see RULE16
         st_nxt.rvalid = 1'b1;
      end

      st_nxt.wt = analog_digital_pin_config_wr && !st_r.wt; // see RULE8

      if (i_wr) begin
         for (int s = 0; s < NSLOT; s++) begin
            // latch loads in either mode; only the enable differs
            if (i_addr == DATA_ADDR[s]) begin
               st_nxt.lat[s] = wv & DATA_MASK[s]; // see RULE12 see RULE14 see RULE13
            end
            if (i_addr == DIR_ADDR[s]) begin
               st_nxt.dir[s] = wv & DATA_MASK[s];
            end
            if ((PU_MASK[s] != 8'h00) && (i_addr == PU_ADDR[s])) begin
               st_nxt.pu[s] = wv & PU_MASK[s]; // see RULE21 see RULE1
            end
         end
         // prohibited values are dropped so the decode stays contiguous
         if (analog_digital_pin_config_wr && st_r.wt && (wv[3:0] <= ANALOG_DIGITAL_PIN_CONFIG_MAX)) begin
            st_nxt.analog_digital_pin_config = wv[3:0]; // see RULE5 see RULE7
         end
      end
   end

   // ***********************************************
   // state register
   // ***********************************************

   // the reset branch loads constants only; the struct is set field by field, dir to all ones, the rest to zero
   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         st_r.analog_digital_pin_config <= ANALOG_DIGITAL_PIN_CONFIG_RST; // see RULE6
         st_r.pu <= {NSLOT{PU_RST}};
         st_r.dir <= {NSLOT{DIR_RST}};
         st_r.lat <= {NSLOT{LAT_RST}}; // see RULE13
         st_r.wt <= 1'b0;
         st_r.rdata <= 8'h00;
         st_r.rvalid <= 1'b0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign o_rdata = st_r.rdata;
   assign o_rvalid = st_r.rvalid;

   // ***********************************************
   // assertions
   // ***********************************************
   default clocking cb @(posedge i_ref_clk);
   endclocking
   default disable iff (!i_reset_n);

   a_reset_clears: assert property (@(posedge i_ref_clk) disable iff (1'b0) // see RULE6
      !i_reset_n |-> (st_r.analog_digital_pin_config == 4'h0) && (st_r.lat == '0) && (o_analog_sel == 9'h1FF))
      else $error("reset left config or latch set");

   a_pu_input_only: assert property ((o_pullup_en & ~st_r.dir) == '0) // see RULE3
      else $error("pull-up on a non-input pin");

   a_pu_follows_sel: assert property ( // see RULE1
      (st_r.dir[SLOT_P1] == 8'hFF) && (i_alt_out_en[SLOT_P1] == 8'h00)
      |-> o_pullup_en[SLOT_P1] == st_r.pu[SLOT_P1])
      else $error("pull-up does not follow its select bit");

   a_pu_fixed_zero: assert property ( // see RULE21
      ((st_r.pu[0] & 8'hBC) == 8'h00) && ((st_r.pu[6] & 8'hFD) == 8'h00))
      else $error("fixed-zero pull-up bit set");

   a_analog_digital_pin_config_wait_one: assert property ( // see RULE8
      analog_digital_pin_config_wr && !st_r.wt |-> o_wait ##1 (!o_wait || !analog_digital_pin_config_wr))
      else $error("configuration write wait not one cycle");

   a_analog_digital_pin_config_byte_wr: assert property ( // see RULE7
      o_wait && !i_bit && (i_wdata[3:0] <= 4'h9) ##1 analog_digital_pin_config_wr && !i_bit
      |=> st_r.analog_digital_pin_config == $past(i_wdata[3:0]))
      else $error("configuration byte write lost");

   a_analog_digital_pin_config_contig: assert property ( // see RULE5
      ($countones(~o_analog_sel) == st_r.analog_digital_pin_config)
      && (((~o_analog_sel) & ((~o_analog_sel) + 9'h001)) == 9'h000))
      else $error("digital pins not the lowest contiguous set");

   a_analog_digital_pin_config_no_bad: assert property (st_r.analog_digital_pin_config <= ANALOG_DIGITAL_PIN_CONFIG_MAX) // see RULE5
      else $error("prohibited configuration value stored");

   a_input_undriven: assert property ((o_pin_oe & st_r.dir) == '0) // see RULE14 see RULE18
      else $error("input-mode pin driven");

   a_drive_latch: assert property ( // see RULE12 see RULE17
      i_wr && !i_bit && (i_addr == DATA_ADDR[SLOT_P1]) && (st_r.dir[SLOT_P1] == 8'h00)
      |=> (o_pin_out[SLOT_P1] == $past(i_wdata)) && (o_pin_oe[SLOT_P1] == 8'hFF))
      else $error("written latch not driven on output pins");

   a_read_out_mode: assert property ( // see RULE15
      i_rd && !i_wr && (i_addr == DATA_ADDR[SLOT_P1]) && (st_r.dir[SLOT_P1] == 8'h00)
      |=> o_rvalid && (o_rdata == $past(st_r.lat[SLOT_P1])))
      else $error("output-mode read not the latch");

   a_read_in_mode: assert property ( // see RULE16
      i_rd && !i_wr && (i_addr == DATA_ADDR[SLOT_P1]) && (st_r.dir[SLOT_P1] == 8'hFF)
      |=> o_rvalid && (o_rdata == $past(pin_q[SLOT_P1])))
      else $error("input-mode read not the pin level");

   a_read_keeps: assert property (!i_wr |=> st_r.lat == $past(st_r.lat)) // see RULE13
      else $error("latch changed without a write");

   a_bit_rmw: assert property ( // see RULE19
      i_wr && i_bit && (i_addr == DATA_ADDR[SLOT_P1])
      |=> ((st_r.lat[SLOT_P1] & ~(8'h01 << $past(i_bit_idx)))
           == ($past(rdv[SLOT_P1]) & ~(8'h01 << $past(i_bit_idx))))
      && (st_r.lat[SLOT_P1][$past(i_bit_idx)] == $past(i_bit_val)))
      else $error("bit write did not rewrite the byte");

   // pull-ups are also cut by an alternate-function output
   a_pu_alt_cut: assert property ((o_pullup_en & i_alt_out_en) == '0) // see RULE3
      else $error("pull-up on an alternate output pin");

   // analog pins never drive, whatever the direction register holds
   a_analog_no_drive: assert property ( // see RULE4
      ((o_pin_oe[SLOT_P8] & ~dig[SLOT_P8]) == 8'h00)
      && ((o_pin_oe[SLOT_P9] & ~dig[SLOT_P9]) == 8'h00))
      else $error("analog pin driven");

   // with every shared pin analog, a port-8 read returns zero
   a_analog_read_zero: assert property ( // see RULE4
      i_rd && (i_addr == DATA_ADDR[SLOT_P8]) && (st_r.analog_digital_pin_config == ANALOG_DIGITAL_PIN_CONFIG_RST)
      |=> o_rdata == 8'h00)
      else $error("analog pin read not zero");

   // a prohibited value leaves the configuration alone
   a_analog_digital_pin_config_bad_keeps: assert property ( // see RULE5
      analog_digital_pin_config_wr && st_r.wt && !i_bit && (i_wdata[3:0] > ANALOG_DIGITAL_PIN_CONFIG_MAX)
      |=> st_r.analog_digital_pin_config == $past(st_r.analog_digital_pin_config))
      else $error("prohibited configuration value taken");

   // an input-mode write lands in the latch but leaves the pad undriven
   a_latch_in_mode: assert property ( // see RULE14
      i_wr && !i_bit && (i_addr == DATA_ADDR[SLOT_P1]) && (st_r.dir[SLOT_P1] == 8'hFF)
      |=> (o_pin_out[SLOT_P1] == $past(i_wdata)) && (o_pin_oe[SLOT_P1] == 8'h00))
      else $error("input-mode write not latched or pin driven");

   // every read strobe is answered exactly one cycle later
   a_rvalid_pulse: assert property (i_rd |=> o_rvalid) // see RULE15 see RULE16
      else $error("read not answered");

   a_rvalid_only: assert property (!i_rd |=> !o_rvalid) // see RULE15 see RULE16
      else $error("read answer without a read");

   c_analog_read: cover property (i_rd && (i_addr == DATA_ADDR[SLOT_P8]) && (st_r.analog_digital_pin_config == ANALOG_DIGITAL_PIN_CONFIG_RST));
   c_analog_digital_pin_config_write: cover property (o_wait ##1 analog_digital_pin_config_wr && !o_wait);
   c_bit_in_port: cover property (i_wr && i_bit && (st_r.dir[SLOT_P1] != 8'h00));
   c_read_pin: cover property (i_rd && (i_addr == DATA_ADDR[SLOT_P8]) && (st_r.analog_digital_pin_config == 4'h9));
   c_pullup_on: cover property (o_pullup_en[SLOT_P1] != 8'h00);

endmodule : plpaps_top
`default_nettype wire

// ===== tb/plpaps_pins.sv
// pin-side model: board drivers, on-chip pull-ups and floating pads
`timescale 1ns/100ps
`default_nettype none
module plpaps_pins (
   input wire logic i_ref_clk,
   input wire logic [plpaps_pkg::NSLOT-1:0][7:0] i_out,
   input wire logic [plpaps_pkg::NSLOT-1:0][7:0] i_oe,
   input wire logic [plpaps_pkg::NSLOT-1:0][7:0] i_pu,
   input wire logic [plpaps_pkg::NSLOT-1:0][7:0] i_board,
   input wire logic [plpaps_pkg::NSLOT-1:0][7:0] i_drv,
   output logic [plpaps_pkg::NSLOT-1:0][7:0] o_level
);
   import plpaps_pkg::*;
   logic flip_r = 1'b0;
   // a floating pad toggles so that a stale level never passes for a valid one
   always @(posedge i_ref_clk) begin
      flip_r <= ~flip_r;
   end
   // device driver wins, then the board, then the weak pull-up
   always_comb begin
      for (int s = 0; s < NSLOT; s++) begin
         for (int b = 0; b < 8; b++) begin
            if (i_oe[s][b]) o_level[s][b] = i_out[s][b];
            else if (i_drv[s][b]) o_level[s][b] = i_board[s][b];
            else if (i_pu[s][b]) o_level[s][b] = 1'b1;
            else o_level[s][b] = flip_r;
         end
      end
   end
endmodule : plpaps_pins
`default_nettype wire

// ===== tb/test_plpaps_top.sv
// self-checking bench of the port latch / pull-up / analog select block
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin error_cnt++; \
   $display("Error t=%0t got=%h exp=%h", $time, g, e); end end
module test_plpaps_top;
   import plpaps_pkg::*;
   logic clk = 1'b0;
   logic rst_n, rd, wr, bt, bval, rvalid, wt;
   logic [15:0] addr;
   logic [2:0] bidx;
   logic [7:0] wdata, rdata, r, r2, e;
   logic [NSLOT-1:0][7:0] pin_in, alt, pin_out, pin_oe, pu_en, board, drv;
   logic [8:0] an_sel;
   int error_cnt = 0;
   int checks_done = 0;
   int seed = 12;
   logic [7:0] expq [$];
   always #50 clk = ~clk;
   plpaps_top plpaps_top_inst (.i_ref_clk(clk), .i_reset_n(rst_n), .i_addr(addr),
      .i_rd(rd), .i_wr(wr), .i_bit(bt), .i_bit_idx(bidx), .i_bit_val(bval),
      .i_wdata(wdata), .o_rdata(rdata), .o_rvalid(rvalid), .o_wait(wt),
      .i_pin_in(pin_in), .i_alt_out_en(alt), .o_pin_out(pin_out), .o_pin_oe(pin_oe),
      .o_pullup_en(pu_en), .o_analog_sel(an_sel));
   plpaps_pins plpaps_pins_inst (.i_ref_clk(clk), .i_out(pin_out), .i_oe(pin_oe),
      .i_pu(pu_en), .i_board(board), .i_drv(drv), .o_level(pin_in));
   // ***********************************************
   // bus tasks and scoreboard
   // ***********************************************
   task automatic acc(input logic [15:0] a, input logic b, input logic [2:0] i,
      input logic [7:0] d);
      @(posedge clk);
      #1;
      addr = a; wr = 1'b1; bt = b; bidx = i; bval = d[0]; wdata = d;
      // the configuration write is held across its wait cycle
      if (a == ANALOG_DIGITAL_PIN_CONFIG_ADDR) begin
         #1;
         `CHK(wt, 1'b1)
         @(posedge clk);
         #1;
         `CHK(wt, 1'b0)
      end
      @(posedge clk);
      #1;
      wr = 1'b0;
      bt = 1'b0;
   endtask : acc
   task automatic rd_chk(input logic [15:0] a, input logic [7:0] x);
      @(posedge clk);
      #1;
      addr = a;
      rd = 1'b1;
      expq.push_back(x);
      @(posedge clk);
      #1;
      rd = 1'b0;
   endtask : rd_chk
   // read data is taken on the falling edge, well clear of the update
   always @(negedge clk) begin
      if (rvalid === 1'b1) begin
         e = (expq.size() > 0) ? expq.pop_front() : 8'hXX;
         `CHK(rdata, e)
      end
   end
   task automatic wrap_up();
      if (expq.size() != 0) error_cnt++;
      $display("checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : wrap_up
   initial begin
      #300000;
      error_cnt++;
      wrap_up();
   end
   // ***********************************************
   // main sequence
   // ***********************************************
   initial begin
      rst_n = 1'b0; rd = 1'b0; wr = 1'b0; bt = 1'b0; bval = 1'b0; bidx = 3'h0;
      addr = 16'h0000; wdata = 8'h00; alt = '0; board = '0; drv = '0;
      repeat (2) @(posedge clk);
      #1;
      rst_n = 1'b1;
      `CHK(an_sel, 9'h1FF)
      `CHK(pin_out, '0)
      for (int s = 0; s < 7; s++) begin
         rd_chk(PU_ADDR[s], 8'h00);
         r = (s == 0) ? 8'hBF : (s == 6) ? 8'hFD : 8'hFF;
         acc(PU_ADDR[s], 1'b0, 3'h0, r);
         rd_chk(PU_ADDR[s], r & PU_MASK[s]);
      end
      repeat (6) @(posedge clk);
      `CHK(pu_en[SLOT_P1], 8'hFF)
      rd_chk(DATA_ADDR[SLOT_P1], 8'hFF);
      alt[SLOT_P1] = 8'h0F;
      #1;
      `CHK(pu_en[SLOT_P1], 8'hF0)
      alt[SLOT_P1] = 8'h00;
      acc(DIR_ADDR[SLOT_P1], 1'b0, 3'h0, 8'h3C);
      `CHK(pu_en[SLOT_P1], 8'h3C)
      $display("test pullup done");
      r = 8'($random(seed));
      acc(DATA_ADDR[SLOT_P1], 1'b0, 3'h0, r);
      acc(DIR_ADDR[SLOT_P1], 1'b0, 3'h0, 8'h00);
      `CHK(pin_out[SLOT_P1], r)
      `CHK(pin_oe[SLOT_P1], 8'hFF)
      rd_chk(DATA_ADDR[SLOT_P1], r);
      `CHK(pin_out[SLOT_P1], r)
      acc(DIR_ADDR[SLOT_P1], 1'b0, 3'h0, 8'hFF);
      r2 = 8'($random(seed));
      acc(DATA_ADDR[SLOT_P1], 1'b0, 3'h0, r2);
      `CHK(pin_oe[SLOT_P1], 8'h00)
      `CHK(pin_out[SLOT_P1], r2)
      r = 8'($random(seed));
      board[SLOT_P1] = r;
      drv[SLOT_P1] = 8'hFF;
      repeat (6) @(posedge clk);
      rd_chk(DATA_ADDR[SLOT_P1], r);
      `CHK(pin_out[SLOT_P1], r2)
      $display("test latch done");
      board[SLOT_P1] = 8'hFF;
      acc(DATA_ADDR[SLOT_P1], 1'b0, 3'h0, 8'h00);
      acc(DIR_ADDR[SLOT_P1], 1'b0, 3'h0, 8'hFE);
      repeat (6) @(posedge clk);
      acc(DATA_ADDR[SLOT_P1], 1'b1, 3'h0, 8'h01);
      `CHK(pin_out[SLOT_P1], 8'hFF)
      `CHK(pin_oe[SLOT_P1], 8'h01)
      board[SLOT_P1] = 8'h00;
      repeat (6) @(posedge clk);
      acc(DATA_ADDR[SLOT_P1], 1'b1, 3'h7, 8'h00);
      `CHK(pin_out[SLOT_P1], 8'h01)
      $display("test bit op done");
      // converter pins stay inputs; the clock runs through every config write
      acc(DIR_ADDR[SLOT_P8], 1'b0, 3'h0, 8'hFF);
      acc(DIR_ADDR[SLOT_P9], 1'b0, 3'h0, 8'hFF);
      // digital pins are taken upward from the first shared pin
      for (int n = 0; n < 10; n++) begin
         acc(ANALOG_DIGITAL_PIN_CONFIG_ADDR, 1'b0, 3'h0, 8'(n));
         `CHK(an_sel, 9'h1FF << n)
         rd_chk(ANALOG_DIGITAL_PIN_CONFIG_ADDR, 8'(n));
      end
      r2 = 8'($random(seed));
      board[SLOT_P8] = r2;
      drv[SLOT_P8] = 8'hFF;
      repeat (6) @(posedge clk);
      rd_chk(DATA_ADDR[SLOT_P8], r2);
      acc(ANALOG_DIGITAL_PIN_CONFIG_ADDR, 1'b0, 3'h0, 8'h0A);
      `CHK(an_sel, 9'h000)
      acc(ANALOG_DIGITAL_PIN_CONFIG_ADDR, 1'b0, 3'h0, 8'h00);
      rd_chk(DATA_ADDR[SLOT_P8], 8'h00);
      acc(ANALOG_DIGITAL_PIN_CONFIG_ADDR, 1'b1, 3'h1, 8'h01);
      `CHK(an_sel, 9'h1FC)
      $display("test analog select done");
      rst_n = 1'b0;
      #1;
      `CHK(pin_out, '0)
      `CHK(an_sel, 9'h1FF)
      @(posedge clk);
      #1;
      rst_n = 1'b1;
      rd_chk(ANALOG_DIGITAL_PIN_CONFIG_ADDR, 8'h00);
      repeat (2) @(posedge clk);
      $display("test second reset done");
      wrap_up();
   end
endmodule : test_plpaps_top
`default_nettype wire
